// ===== include/lin_wake_defines.svh
// Constants for the single-wire bus wake, fault and slope control block
`ifndef LIN_WAKE_DEFINES_SVH
`define LIN_WAKE_DEFINES_SVH
`define CLK_FREQ_KHZ 100000
`define WAKE_FILTER_MIN_US 30
`define WAKE_FILTER_MAX_US 150
`define TX_TIMEOUT_TYP_MS 20
`define BUS_TIMEOUT_TYP_MS 20
`define WAKE_FILTER_CYC ((`WAKE_FILTER_MIN_US * `CLK_FREQ_KHZ + 999) / 1000)
`define WAKE_MAX_CYC ((`WAKE_FILTER_MAX_US * `CLK_FREQ_KHZ) / 1000)
`define TX_TIMEOUT_CYC (`TX_TIMEOUT_TYP_MS * `CLK_FREQ_KHZ)
`define BUS_TIMEOUT_CYC (`BUS_TIMEOUT_TYP_MS * `CLK_FREQ_KHZ)
`define XCVR_MODE_RST 2'h3
`define XCVR_EN_MAX_US 18
`define XCVR_EN_CYC ((`XCVR_EN_MAX_US * `CLK_FREQ_KHZ) / 1000)
`define CNT_W 22
`endif

// ===== include/lin_wake_pkg.sv
// Types shared by the bus wake, fault and slope control block
package lin_wake_pkg;
    typedef enum logic [1:0] {
        XM_NORMAL = 2'h0,
        XM_WAKE = 2'h1,
        XM_RXONLY = 2'h2,
        XM_OFF = 2'h3
    } xcvr_mode_t;
    typedef enum logic [2:0] {
        PM_NORMAL = 3'h0,
        PM_STOP = 3'h1,
        PM_SLEEP = 3'h2,
        PM_RESTART = 3'h3,
        PM_FAILSAFE = 3'h4
    } power_mode_t;
    typedef struct packed {
        logic wake_irq;
        logic goto_restart;
        logic wdog_enable;
    } wake_req_t;
    typedef struct packed {
        logic low_slope;
        logic slope_bypass;
    } slope_cfg_t;
endpackage

// ===== logic/lin_wake_fault_slope_ctrl.sv
// Wake detection, fault monitoring and slope control for the bus transceiver
//
// Summary of operation
// - After a wake the mode field still reads wake capable; receive held low.
// - Besides power-mode entry, wake rearms only after another mode is written, then wake capable again.
// - Entering stop, sleep or fail-safe power mode rearms wake automatically.
// - Wake in stop or normal: interrupt low, status flag set, receive low.
// - Stop-mode wake re-enables a disabled watchdog when so configured.
// - Sleep-mode wake, dominant 30 us or longer with no upper limit, requests restart; receive low.
// - Wake out of sleep leaves the interrupt output high.
// - Wake in fail-safe or restart requests restart, interrupt high, rx low.
// - Transmit dominant past time-out disables driver and sets fault flag.
// - Driver re-enabled once transmit goes recessive; mode unchanged.
// - Bus dominant past time-out in normal or receive-only sets fault flag.
// - Bus supply undervoltage disables driver and receiver until it clears.
// - Normal slope by default; low-slope bit changes transmitter slope only.
// - Low-slope selection applies on select rising edge, normal mode only.
// - Slope bypass applies on select rising edge in normal power mode.
// - Wake is dominant longer than filter time, registered on release edge.
// - Transceiver powers up off; off mode ignores bus wakes.
// - Transmit dominant time-out is 20 ms typical, 16 to 24 ms.
`timescale 1ns/1ps
`include "lin_wake_defines.svh"
module lin_wake_fault_slope_ctrl import lin_wake_pkg::*; #(
    parameter int unsigned TX_TIMEOUT_CYC = `TX_TIMEOUT_CYC,
    parameter int unsigned BUS_TIMEOUT_CYC = `BUS_TIMEOUT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] xcvr_mode_sel_in,
    input wire logic xcvr_mode_wr_in,
    input wire logic [2:0] power_mode_in,
    input wire logic wdog_enabled_in,
    input wire logic wdog_on_bus_wake_in,
    input wire logic spi_select_n_in,
    input wire logic low_slope_sel_in,
    input wire logic slope_bypass_in,
    input wire logic fault_clear_in,
    input wire logic wake_status_clear_in,
    input wire logic bus_transmit_in,
    input wire logic bus_level_in,
    input wire logic bus_supply_uv_in,
    output logic [1:0] xcvr_mode_sel_out,
    output logic bus_receive_out,
    output logic bus_drive_low_out,
    output logic rx_enable_out,
    output logic int_n_out,
    output logic wake_source_status_out,
    output logic xcvr_fault_flag_out,
    output logic goto_restart_out,
    output logic wdog_enable_req_out,
    output logic low_slope_out,
    output logic slope_bypass_out
);
    localparam int unsigned WAKE_CYC = `WAKE_FILTER_CYC;
    localparam int unsigned CW = `CNT_W;

    // Three-stage synchronisers for pins; change counts when stages 2 and 3 agree
    logic [2:0] tx_s_q, bus_s_q, cs_s_q, uv_s_q;
    logic tx_q, bus_q, cs_q, uv_q;
    logic tx_d, bus_d, cs_d, uv_d;
    always_comb begin
        tx_d = (tx_s_q[1] == tx_s_q[2]) ? tx_s_q[2] : tx_q;
        bus_d = (bus_s_q[1] == bus_s_q[2]) ? bus_s_q[2] : bus_q;
        cs_d = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_q;
        uv_d = (uv_s_q[1] == uv_s_q[2]) ? uv_s_q[2] : uv_q;
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_s_q <= 3'h7;
            bus_s_q <= 3'h7;
            cs_s_q <= 3'h7;
            uv_s_q <= 3'h0;
            tx_q <= 1'b1;
            bus_q <= 1'b1;
            cs_q <= 1'b1;
            uv_q <= 1'b0;
        end else begin
            tx_s_q <= {tx_s_q[1:0], bus_transmit_in};
            bus_s_q <= {bus_s_q[1:0], bus_level_in};
            cs_s_q <= {cs_s_q[1:0], spi_select_n_in};
            uv_s_q <= {uv_s_q[1:0], bus_supply_uv_in};
            tx_q <= tx_d;
            bus_q <= bus_d;
            cs_q <= cs_d;
            uv_q <= uv_d;
        end
    end

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] c);
        sat_inc = (c == {CW{1'b1}}) ? c : c + 1'b1;
    endfunction

    // Main control state
    logic [1:0] mode_q, mode_d;
    logic armed_q, armed_d, woken_q, woken_d;
    logic [CW-1:0] wk_cnt_q, wk_cnt_d, tx_cnt_q, tx_cnt_d;
    logic [CW-1:0] bus_cnt_q, bus_cnt_d;
    logic tx_block_q, tx_block_d, fault_q, fault_d, stat_q, stat_d;
    logic int_n_q, int_n_d, rst_req_q, rst_req_d, wd_q, wd_d;
    logic ls_q, ls_d, byp_q, byp_d;
    logic [2:0] pm_prev_q, pm_prev_d;
    logic rx_q, rx_d, drv_q, drv_d, rxen_q, rxen_d;
    logic wake_ev, pm_sleepish, pm_entry, norm_rx;
    power_mode_t pm;
    wake_req_t req;
    slope_cfg_t scfg;

    always_comb begin
        pm = power_mode_t'(power_mode_in);
        pm_sleepish = (pm == PM_STOP) || (pm == PM_SLEEP) ||
                      (pm == PM_FAILSAFE);
        // Any change into one of these modes counts, sleep to fail-safe too
        pm_entry = pm_sleepish && (power_mode_in != pm_prev_q);
        mode_d = mode_q;
        armed_d = armed_q;
        woken_d = woken_q;
        pm_prev_d = power_mode_in;
        // Host mode write; rewriting wake-capable alone does not rearm
        if (xcvr_mode_wr_in) begin
            mode_d = xcvr_mode_sel_in;
            if (xcvr_mode_sel_in != XM_WAKE) begin
                armed_d = 1'b1;
                woken_d = 1'b0;
            end
        end
        if (pm == PM_FAILSAFE && mode_d != XM_WAKE) begin
            mode_d = XM_WAKE;
        end
        // Rearm on entry into stop, sleep or fail-safe
        if (pm_entry) begin
            armed_d = 1'b1;
            woken_d = 1'b0;
        end
        // Wake filter: dominant longer than filter time, taken on release
        wk_cnt_d = bus_q ? '0 : sat_inc(wk_cnt_q);
        wake_ev = (mode_q == XM_WAKE) && armed_q && bus_q &&
                  (wk_cnt_q >= CW'(WAKE_CYC));
        req = '0;
        if (wake_ev) begin
            armed_d = 1'b0;
            woken_d = 1'b1;
            unique case (pm)
                PM_NORMAL, PM_STOP: begin
                    req.wake_irq = 1'b1;
                    req.wdog_enable = (pm == PM_STOP) && !wdog_enabled_in &&
                                      wdog_on_bus_wake_in;
                end
                PM_SLEEP, PM_FAILSAFE, PM_RESTART: begin
                    req.goto_restart = 1'b1;
                end
                default: ;
            endcase
        end
        stat_d = wake_ev | (stat_q & ~wake_status_clear_in);
        int_n_d = ~req.wake_irq;
        rst_req_d = req.goto_restart;
        wd_d = req.wdog_enable;
        // Transmit dominant time-out and recovery
        tx_cnt_d = tx_q ? '0 : sat_inc(tx_cnt_q);
        tx_block_d = tx_block_q;
        if (!tx_q && tx_cnt_q >= CW'(TX_TIMEOUT_CYC)) tx_block_d = 1'b1;
        if (tx_q) tx_block_d = 1'b0;
        // Bus clamp in normal or receive-only mode
        norm_rx = (mode_q == XM_NORMAL) || (mode_q == XM_RXONLY);
        bus_cnt_d = (bus_q || !norm_rx) ? '0 : sat_inc(bus_cnt_q);
        fault_d = (fault_q & ~fault_clear_in) |
                  (!tx_q && tx_cnt_q >= CW'(TX_TIMEOUT_CYC)) |
                  (norm_rx && !bus_q &&
                   bus_cnt_q >= CW'(BUS_TIMEOUT_CYC));
        // Slope settings latched on select rising edge in normal mode
        scfg = '{low_slope: ls_q, slope_bypass: byp_q};
        if (cs_d && !cs_q && pm == PM_NORMAL) begin
            scfg.low_slope = low_slope_sel_in;
            scfg.slope_bypass = slope_bypass_in;
        end
        ls_d = scfg.low_slope;
        byp_d = scfg.slope_bypass;
        // Pin outputs, with undervoltage gating
        drv_d = (mode_q == XM_NORMAL) && !tx_q && !tx_block_d && !uv_q;
        rxen_d = norm_rx && !uv_q;
        rx_d = woken_d ? 1'b0 : (rxen_d ? bus_q : 1'b1);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= `XCVR_MODE_RST;
            armed_q <= 1'b1;
            woken_q <= 1'b0;
            pm_prev_q <= 3'h0;
            wk_cnt_q <= '0;
            tx_cnt_q <= '0;
            bus_cnt_q <= '0;
            tx_block_q <= 1'b0;
            fault_q <= 1'b0;
            stat_q <= 1'b0;
            int_n_q <= 1'b1;
            rst_req_q <= 1'b0;
            wd_q <= 1'b0;
            ls_q <= 1'b0;
            byp_q <= 1'b0;
            rx_q <= 1'b1;
            drv_q <= 1'b0;
            rxen_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            armed_q <= armed_d;
            woken_q <= woken_d;
            pm_prev_q <= pm_prev_d;
            wk_cnt_q <= wk_cnt_d;
            tx_cnt_q <= tx_cnt_d;
            bus_cnt_q <= bus_cnt_d;
            tx_block_q <= tx_block_d;
            fault_q <= fault_d;
            stat_q <= stat_d;
            int_n_q <= int_n_d;
            rst_req_q <= rst_req_d;
            wd_q <= wd_d;
            ls_q <= ls_d;
            byp_q <= byp_d;
            rx_q <= rx_d;
            drv_q <= drv_d;
            rxen_q <= rxen_d;
        end
    end

    assign xcvr_mode_sel_out = mode_q;
    assign bus_receive_out = rx_q;
    assign bus_drive_low_out = drv_q;
    assign rx_enable_out = rxen_q;
    assign int_n_out = int_n_q;
    assign wake_source_status_out = stat_q;
    assign xcvr_fault_flag_out = fault_q;
    assign goto_restart_out = rst_req_q;
    assign wdog_enable_req_out = wd_q;
    assign low_slope_out = ls_q;
    assign slope_bypass_out = byp_q;

    // Checks
    a_woken_rx_low: assert property (@(posedge clk_in) disable iff (rst_in)
        woken_q |-> !bus_receive_out) else $error("rx not low");
    a_rewrite_no_rearm: assert property (@(posedge clk_in)
        disable iff (rst_in) (!armed_q && xcvr_mode_wr_in &&
        xcvr_mode_sel_in == XM_WAKE && !pm_entry)
        |=> !armed_q) else $error("rearmed by rewrite");
    a_sleep_no_irq: assert property (@(posedge clk_in) disable iff (rst_in)
        (wake_ev && pm == PM_SLEEP) |=> int_n_out && goto_restart_out)
        else $error("sleep wake wrong");
    a_stop_wake_irq: assert property (@(posedge clk_in) disable iff (rst_in)
        (wake_ev && pm == PM_STOP) |=> !int_n_out ##0 stat_q)
        else $error("stop wake not signalled");
    a_tx_block: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_block_q |-> !bus_drive_low_out) else $error("driving");
    a_tx_recover: assert property (@(posedge clk_in) disable iff (rst_in)
        (tx_block_q && tx_q) |=> !tx_block_q) else $error("no recov");
    a_fault_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
        (fault_q && !fault_clear_in) |=> fault_q) else $error("lost");
    a_uv_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        uv_q |=> !rx_enable_out && !bus_drive_low_out)
        else $error("uv not gated");
    a_off_no_wake: assert property (@(posedge clk_in) disable iff (rst_in)
        (mode_q == XM_OFF && !wake_source_status_out) |=>
        !wake_source_status_out && int_n_out && !goto_restart_out)
        else $error("off wake");
    a_slope_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !(cs_d && !cs_q) |=> $stable(low_slope_out))
        else $error("slope moved");
    c_stop_wake: cover property (@(posedge clk_in) wake_ev && pm == PM_STOP);
    c_sleep_wake: cover property (@(posedge clk_in) wake_ev && pm == PM_SLEEP);
    c_tx_timeout: cover property (@(posedge clk_in) tx_block_q);
    c_slope_set: cover property (@(posedge clk_in) $rose(low_slope_out));
endmodule

// ===== sim/lin_bus_model.sv
// Far-side bus model: pulled-up single wire with an outside dominant source
`timescale 1ns/1ps
module lin_bus_model (
    input wire logic drive_low_in,
    input wire logic ext_dom_in,
    output logic bus_level_out
);
    // Pull-up keeps the wire recessive unless either party pulls it low
    assign bus_level_out = !(drive_low_in || ext_dom_in);
endmodule

// ===== sim/lin_wake_fault_slope_ctrl_tb.sv
// Self-checking bench for the wake, fault and slope control block
`timescale 1ns/1ps
`include "lin_wake_defines.svh"
module lin_wake_fault_slope_ctrl_tb import lin_wake_pkg::*;;
    localparam int TO = 100;
    localparam int W = `WAKE_FILTER_CYC + 100;
    logic clk_in, rst_in, xcvr_mode_wr_in, wdog_enabled_in;
    logic [1:0] xcvr_mode_sel_in;
    logic [2:0] power_mode_in;
    logic wdog_on_bus_wake_in, spi_select_n_in, low_slope_sel_in;
    logic slope_bypass_in, fault_clear_in, wake_status_clear_in;
    logic bus_transmit_in, bus_level_in, bus_supply_uv_in, ext_dom;
    logic [1:0] xcvr_mode_sel_out;
    logic bus_receive_out, bus_drive_low_out, rx_enable_out, int_n_out;
    logic wake_source_status_out, xcvr_fault_flag_out, goto_restart_out;
    logic wdog_enable_req_out, low_slope_out, slope_bypass_out;
    logic seen_int, seen_rst, seen_wd;
    int error_cnt = 0;
    int total_checks = 0;

    lin_wake_fault_slope_ctrl #(.TX_TIMEOUT_CYC(TO), .BUS_TIMEOUT_CYC(TO))
        dut_u (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .xcvr_mode_sel_in(xcvr_mode_sel_in),
        .xcvr_mode_wr_in(xcvr_mode_wr_in),
        .power_mode_in(power_mode_in),
        .wdog_enabled_in(wdog_enabled_in),
        .wdog_on_bus_wake_in(wdog_on_bus_wake_in),
        .spi_select_n_in(spi_select_n_in),
        .low_slope_sel_in(low_slope_sel_in),
        .slope_bypass_in(slope_bypass_in),
        .fault_clear_in(fault_clear_in),
        .wake_status_clear_in(wake_status_clear_in),
        .bus_transmit_in(bus_transmit_in),
        .bus_level_in(bus_level_in),
        .bus_supply_uv_in(bus_supply_uv_in),
        .xcvr_mode_sel_out(xcvr_mode_sel_out),
        .bus_receive_out(bus_receive_out),
        .bus_drive_low_out(bus_drive_low_out),
        .rx_enable_out(rx_enable_out),
        .int_n_out(int_n_out),
        .wake_source_status_out(wake_source_status_out),
        .xcvr_fault_flag_out(xcvr_fault_flag_out),
        .goto_restart_out(goto_restart_out),
        .wdog_enable_req_out(wdog_enable_req_out),
        .low_slope_out(low_slope_out),
        .slope_bypass_out(slope_bypass_out)
    );
    lin_bus_model bus_u (.drive_low_in(bus_drive_low_out),
        .ext_dom_in(ext_dom), .bus_level_out(bus_level_in));

    // Free-running 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic set_mode(input logic [1:0] m);
        @(negedge clk_in);
        xcvr_mode_sel_in = m;
        xcvr_mode_wr_in = 1'b1;
        @(negedge clk_in);
        xcvr_mode_wr_in = 1'b0;
        tick(2);
    endtask

    // Pulses the fault or status clear for one cycle
    task automatic clr(input logic f, input logic s);
        @(negedge clk_in);
        fault_clear_in = f;
        wake_status_clear_in = s;
        @(negedge clk_in);
        fault_clear_in = 1'b0;
        wake_status_clear_in = 1'b0;
        tick(2);
    endtask

    // Holds the bus dominant n cycles, then watches the one-cycle pulses
    task automatic wake(input int n);
        seen_int = 1'b0;
        seen_rst = 1'b0;
        seen_wd = 1'b0;
        ext_dom = 1'b1;
        tick(n);
        ext_dom = 1'b0;
        repeat (20) begin
            @(negedge clk_in);
            if (int_n_out === 1'b0) seen_int = 1'b1;
            if (goto_restart_out === 1'b1) seen_rst = 1'b1;
            if (wdog_enable_req_out === 1'b1) seen_wd = 1'b1;
        end
    endtask

    task automatic sel_pulse();
        spi_select_n_in = 1'b0;
        tick(5);
        spi_select_n_in = 1'b1;
        tick(8);
    endtask

    // Watchdog sized well above the roughly 30k cycles of the tests
    initial begin
        #600_000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end

    // Main sequence
    initial begin
        {xcvr_mode_sel_in, xcvr_mode_wr_in, wdog_enabled_in} = 4'h0;
        {wdog_on_bus_wake_in, low_slope_sel_in, slope_bypass_in} = 3'h0;
        {fault_clear_in, wake_status_clear_in, ext_dom} = 3'h0;
        {spi_select_n_in, bus_transmit_in, bus_supply_uv_in} = 3'h6;
        power_mode_in = PM_NORMAL;
        rst_in = 1'b1;
        tick(10);
        rst_in = 1'b0;
        tick(6);
        check(xcvr_mode_sel_out, XM_OFF);
        check({low_slope_out, slope_bypass_out}, 3'h0);
        wake(W);
        check(wake_source_status_out, 1'b0);
        $display("test reset and off mode done");
        power_mode_in = PM_STOP;
        wdog_on_bus_wake_in = 1'b1;
        set_mode(XM_WAKE);
        wake(W);
        check({seen_int, seen_wd, seen_rst}, 3'h6);
        check(wake_source_status_out, 1'b1);
        check({xcvr_mode_sel_out, bus_receive_out}, 3'h2);
        $display("test stop wake done");
        power_mode_in = PM_NORMAL;
        clr(1'b0, 1'b1);
        set_mode(XM_WAKE);
        wake(W);
        check({seen_int, wake_source_status_out}, 3'h0);
        set_mode(XM_NORMAL);
        set_mode(XM_WAKE);
        wake(W);
        check({seen_int, wake_source_status_out}, 3'h3);
        check(bus_receive_out, 1'b0);
        $display("test rearm by mode toggle done");
        power_mode_in = PM_SLEEP;
        clr(1'b0, 1'b1);
        wake(W);
        check({seen_rst, seen_int, bus_receive_out}, 3'h4);
        check(wake_source_status_out, 1'b1);
        power_mode_in = PM_FAILSAFE;
        tick(3);
        wake(W);
        check({seen_rst, seen_int, bus_receive_out}, 3'h4);
        power_mode_in = PM_RESTART;
        set_mode(XM_NORMAL);
        check(bus_receive_out, 1'b1);
        set_mode(XM_WAKE);
        wake(`WAKE_FILTER_CYC - 200);
        check(seen_rst, 1'b0);
        wake(W);
        check({seen_rst, seen_int, bus_receive_out}, 3'h4);
        $display("test sleep and restart wakes done");
        power_mode_in = PM_NORMAL;
        set_mode(XM_NORMAL);
        clr(1'b1, 1'b1);
        tick(`XCVR_EN_CYC);
        bus_transmit_in = 1'b0;
        tick(10);
        check(bus_drive_low_out, 1'b1);
        tick(TO + 20);
        check({bus_drive_low_out, xcvr_fault_flag_out}, 3'h1);
        bus_transmit_in = 1'b1;
        tick(10);
        bus_transmit_in = 1'b0;
        tick(10);
        check({bus_drive_low_out, xcvr_mode_sel_out}, 3'h4);
        bus_transmit_in = 1'b1;
        tick(10);
        check(xcvr_fault_flag_out, 1'b1);
        clr(1'b1, 1'b0);
        check(xcvr_fault_flag_out, 1'b0);
        ext_dom = 1'b1;
        tick(TO + 20);
        ext_dom = 1'b0;
        tick(8);
        check({xcvr_fault_flag_out, xcvr_mode_sel_out}, 3'h4);
        $display("test transmit and bus time-outs done");
        bus_supply_uv_in = 1'b1;
        tick(6);
        bus_transmit_in = 1'b0;
        tick(10);
        check({bus_drive_low_out, rx_enable_out}, 3'h0);
        bus_transmit_in = 1'b1;
        bus_supply_uv_in = 1'b0;
        tick(8);
        check({rx_enable_out, xcvr_mode_sel_out}, 3'h4);
        $display("test supply undervoltage done");
        {low_slope_sel_in, slope_bypass_in} = 2'h3;
        power_mode_in = PM_STOP;
        sel_pulse();
        check({low_slope_out, slope_bypass_out}, 3'h0);
        power_mode_in = PM_NORMAL;
        spi_select_n_in = 1'b0;
        tick(8);
        check({low_slope_out, slope_bypass_out}, 3'h0);
        sel_pulse();
        check({low_slope_out, slope_bypass_out}, 3'h3);
        check(xcvr_mode_sel_out, XM_NORMAL);
        $display("test slope selection done");
        results();
    end
endmodule
